// ### include/iao_regs.vh
// Constants for the integer and format-independent ALU operations.
`ifndef IAO_REGS_VH
`define IAO_REGS_VH

// ============================================================
// Opcodes (five-bit base operation field)
`define IAO_OP_INT_ADD       5'h01
`define IAO_OP_INT_COMPARE   5'h03
`define IAO_OP_INT_MAXIMUM   5'h04
`define IAO_OP_INT_MINIMUM   5'h05
`define IAO_OP_INT_TO_FLOAT  5'h06
`define IAO_OP_INT_SCALED    5'h07
`define IAO_OP_BITWISE_OR    5'h10
`define IAO_OP_BITWISE_AND   5'h11
`define IAO_OP_BITWISE_XOR   5'h12
`define IAO_OP_LOGICAL_SHIFT 5'h13
`define IAO_OP_ARITH_SHIFT   5'h14
`define IAO_OP_FUNNEL_SHIFT  5'h15
`define IAO_OP_MOVE          5'h18
`define IAO_OP_MODE_LOAD     5'h1f

// ============================================================
// Flag positions in the thirteen-bit status word
`define IAO_FLAG_COUNT     13
`define IAO_F_CARRY        0
`define IAO_F_INVALID      1
`define IAO_F_RESERVED     2
`define IAO_F_SIGN         3
`define IAO_F_UNDERFLOW    4
`define IAO_F_OVERFLOW     5
`define IAO_F_WINNER       6
`define IAO_F_INEXACT      7
`define IAO_F_ZERO         8
`define IAO_F_GREATER      9
`define IAO_F_EQUAL        10
`define IAO_F_LESS         11
`define IAO_F_UNORDERED    12

// ============================================================
// Relevant-flag masks per operation
`define IAO_MASK_ADD       13'h0129
`define IAO_MASK_COMPARE   13'h0e09
`define IAO_MASK_MAXMIN    13'h0148
`define IAO_MASK_CONVERT   13'h01b8
`define IAO_MASK_LOGIC     13'h0108
`define IAO_MASK_SHIFT     13'h010a
`define IAO_MASK_NONE      13'h0000

// ============================================================
// Reset values and float format constants
`define IAO_STATUS_RESET   13'h0000
`define IAO_MODE_RESET     32'h00000000
`define IAO_RESULT_RESET   64'h0000000000000000
`define IAO_DBL_BIAS       13'h03ff
`define IAO_SGL_BIAS       13'h007f
`define IAO_DBL_EXP_MAX    13'h07ff
`define IAO_SGL_EXP_MAX    13'h00ff
`define IAO_HEX_EXP_SHIFT  2

`endif

// ### rtl/iao_alu.v
// Integer and format-independent ALU operations with status capture.
`timescale 1ns/1ps
`include "iao_regs.vh"

// Behaviour
// - Opcodes 10000-10101 select integer logic and shifts.
// - 11000 moves, 11111 loads mode, any class.
// - Compare sets exactly one of greater, less, equal.
// - Maximum outputs the more positive operand.
// - Minimum outputs more negative; winner flag marks choice.
// - Integer to float, 32 or 64 bit result.
// - Scaled conversion adds scale exponent, radix 2/16.
// - Logic ops sign-extend 32-bit inputs first.
// - XOR with all ones inverts every bit.
// - Shifts refused in mixed precision; signed count.
// - Logical shift right positive, left negative, zero fill.
// - Arithmetic right shift replicates the top bit.
// - Funnel shift over P,T,P aligned with T.
// - Move passes P unchanged, no exceptions.
// - Mode load captures source port on clock edge.
// - Thirteen-bit flag word; move and mode load set no flags.
// - Only relevant flags clocked into status.
// - Carry holds carry-out of add or compare.

module iao_alu #(
  parameter WIDTH = 64
) (
  input  wire              ref_clk,
  input  wire              reset,
  input  wire              op_valid,
  input  wire [4:0]        opcode,
  input  wire              int_class,
  input  wire              in_double,
  input  wire              out_double,
  input  wire              hex_format,
  input  wire [WIDTH-1:0]  p_operand,
  input  wire [WIDTH-1:0]  t_operand,
  input  wire [WIDTH-1:0]  q_operand,
  input  wire [31:0]       mode_source_port,
  output reg  [WIDTH-1:0]  result_reg,
  output reg               result_valid_reg,
  output reg               op_refused_reg,
  output reg  [`IAO_FLAG_COUNT-1:0] status_reg,
  output reg  [31:0]       mode_reg
);

  // ============================================================
  // Precision conversion of the integer operands
  wire [63:0] p_ext;
  wire [63:0] t_ext;
  wire        mixed_precision;

  assign p_ext = in_double ? p_operand : {{32{p_operand[31]}}, p_operand[31:0]};
  assign t_ext = in_double ? t_operand : {{32{t_operand[31]}}, t_operand[31:0]};
  assign mixed_precision = in_double ^ out_double;

  // ============================================================
  // Add uses its own sum path; compare uses a separate subtract path for the carry
  wire [64:0] add_sum;
  wire [64:0] sub_diff;
  wire        p_greater;
  wire        p_equal;

  assign add_sum  = {1'b0, p_ext} + {1'b0, t_ext};
  assign sub_diff = {1'b0, p_ext} + {1'b0, ~t_ext} + 65'h1;
  assign p_equal  = (p_ext == t_ext);
  assign p_greater = ($signed(p_ext) > $signed(t_ext));

  // ============================================================
  // Shift count decode
  reg  signed [7:0] shift_count;
  reg         [7:0] shift_mag;
  reg               shift_right;
  reg               shift_overrange;
  reg         [7:0] width_sel;

  always @* begin
    if (in_double) begin
      shift_count = {q_operand[6], q_operand[6:0]};
      width_sel   = 8'h40;
    end else begin
      shift_count = {{2{q_operand[5]}}, q_operand[5:0]};
      width_sel   = 8'h20;
    end
    shift_right     = ~shift_count[7];
    shift_mag       = shift_right ? shift_count : (8'h00 - shift_count);
    shift_overrange = (shift_mag >= width_sel);
  end

  // ============================================================
  // Logical, arithmetic and funnel shift datapath
  reg [63:0]  shift_src;
  reg [63:0]  logical_res;
  reg [63:0]  arith_res;
  reg [63:0]  funnel_res;
  reg [191:0] funnel_word;
  reg [191:0] funnel_shifted;
  reg [7:0]   funnel_amt;
  reg         sign_fill;

  always @* begin
    shift_src = in_double ? p_operand : {32'h00000000, p_operand[31:0]};
    sign_fill = in_double ? p_operand[63] : p_operand[31];
    if (shift_overrange) begin
      logical_res = 64'h0000000000000000;
    end else if (shift_right) begin
      logical_res = shift_src >> shift_mag;
    end else begin
      logical_res = shift_src << shift_mag;
    end
    if (shift_right) begin
      if (shift_overrange) begin
        arith_res = {64{sign_fill}};
      end else begin
        arith_res = ($signed(p_ext) >>> shift_mag);
      end
    end else begin
      arith_res = logical_res;
    end
    if (in_double) begin
      funnel_word = {p_operand, t_operand, p_operand};
    end else begin
      funnel_word = {96'h0, p_operand[31:0], t_operand[31:0], p_operand[31:0]};
    end
    funnel_amt     = width_sel + shift_count;
    funnel_shifted = funnel_word >> funnel_amt;
    funnel_res     = in_double ? funnel_shifted[63:0] : {32'h00000000, funnel_shifted[31:0]};
    if (!in_double) begin
      arith_res = {32'h00000000, arith_res[31:0]};
    end
  end

  // ============================================================
  // Integer to floating-point conversion
  reg        cvt_neg;
  reg [63:0] cvt_mag;
  reg [63:0] cvt_norm;
  reg [6:0]  cvt_pos;
  reg signed [12:0] scale_exp;
  reg signed [12:0] biased_exp;
  reg        cvt_dropped;
  reg        cvt_over;
  reg        cvt_under;
  reg [63:0] cvt_res;
  integer    bit_idx;

  always @* begin
    cvt_neg = t_ext[63];
    cvt_mag = cvt_neg ? (64'h0000000000000000 - t_ext) : t_ext;
    cvt_pos = 7'h00;
    for (bit_idx = 0; bit_idx < 64; bit_idx = bit_idx + 1) begin
      if (cvt_mag[bit_idx]) begin
        cvt_pos = bit_idx[6:0];
      end
    end
    cvt_norm  = cvt_mag << (7'h3f - cvt_pos);
    scale_exp = 13'h0000;
    if (opcode == `IAO_OP_INT_SCALED) begin
      if (out_double) begin
        scale_exp = {2'b00, q_operand[62:52]} - `IAO_DBL_BIAS;
      end else begin
        scale_exp = {5'h00, q_operand[30:23]} - `IAO_SGL_BIAS;
      end
      if (hex_format) begin
        scale_exp = scale_exp <<< `IAO_HEX_EXP_SHIFT;
      end
    end
    biased_exp = {6'h00, cvt_pos} + scale_exp;
    if (out_double) begin
      biased_exp  = biased_exp + `IAO_DBL_BIAS;
      cvt_dropped = |cvt_norm[10:0];
      cvt_over    = (biased_exp >= $signed(`IAO_DBL_EXP_MAX));
    end else begin
      biased_exp  = biased_exp + `IAO_SGL_BIAS;
      cvt_dropped = |cvt_norm[39:0];
      cvt_over    = (biased_exp >= $signed(`IAO_SGL_EXP_MAX));
    end
    cvt_under = (biased_exp <= 13'sh0000);
    if (cvt_mag == 64'h0000000000000000) begin
      cvt_res  = 64'h0000000000000000;
      cvt_over = 1'b0;
      cvt_under = 1'b0;
      cvt_dropped = 1'b0;
    end else if (out_double) begin
      if (cvt_over) begin
        cvt_res = {cvt_neg, 11'h7ff, 52'h0};
      end else if (cvt_under) begin
        cvt_res = {cvt_neg, 63'h0};
      end else begin
        cvt_res = {cvt_neg, biased_exp[10:0], cvt_norm[62:11]};
      end
    end else begin
      if (cvt_over) begin
        cvt_res = {32'h00000000, cvt_neg, 8'hff, 23'h0};
      end else if (cvt_under) begin
        cvt_res = {32'h00000000, cvt_neg, 31'h0};
      end else begin
        cvt_res = {32'h00000000, cvt_neg, biased_exp[7:0], cvt_norm[62:40]};
      end
    end
  end

  // ============================================================
  // Operation select, flag generation and relevance mask
  reg [63:0] op_result;
  reg [`IAO_FLAG_COUNT-1:0] flags;
  reg [`IAO_FLAG_COUNT-1:0] flag_mask;
  reg        op_known;
  reg        op_refused;
  reg        pick_t;
  reg        int_result;

  always @* begin
    op_result  = 64'h0000000000000000;
    flags      = 13'h0000;
    flag_mask  = `IAO_MASK_NONE;
    op_known   = 1'b1;
    op_refused = 1'b0;
    pick_t     = 1'b0;
    int_result = 1'b1;
    case (opcode)
      `IAO_OP_INT_ADD: begin
        op_result = add_sum[63:0];
        flags[`IAO_F_CARRY]    = add_sum[64];
        flags[`IAO_F_OVERFLOW] = (p_ext[63] == t_ext[63]) && (add_sum[63] != p_ext[63]);
        flag_mask = `IAO_MASK_ADD;
      end
      `IAO_OP_INT_COMPARE: begin
        op_result = sub_diff[63:0];
        flags[`IAO_F_CARRY]   = sub_diff[64];
        flags[`IAO_F_GREATER] = p_greater;
        flags[`IAO_F_EQUAL]   = p_equal;
        flags[`IAO_F_LESS]    = ~p_greater & ~p_equal;
        flag_mask = `IAO_MASK_COMPARE;
      end
      `IAO_OP_INT_MAXIMUM: begin
        pick_t    = ~p_greater & ~p_equal;
        op_result = pick_t ? t_ext : p_ext;
        flags[`IAO_F_WINNER] = pick_t;
        flag_mask = `IAO_MASK_MAXMIN;
      end
      `IAO_OP_INT_MINIMUM: begin
        pick_t    = p_greater;
        op_result = pick_t ? t_ext : p_ext;
        flags[`IAO_F_WINNER] = pick_t;
        flag_mask = `IAO_MASK_MAXMIN;
      end
      `IAO_OP_INT_TO_FLOAT, `IAO_OP_INT_SCALED: begin
        op_result  = cvt_res;
        int_result = 1'b0;
        flags[`IAO_F_SIGN]      = cvt_neg;
        flags[`IAO_F_ZERO]      = (cvt_mag == 64'h0000000000000000);
        flags[`IAO_F_OVERFLOW]  = cvt_over;
        flags[`IAO_F_UNDERFLOW] = cvt_under;
        flags[`IAO_F_INEXACT]   = cvt_dropped | cvt_over | cvt_under;
        flag_mask = `IAO_MASK_CONVERT;
      end
      `IAO_OP_BITWISE_OR: begin
        op_result = p_ext | t_ext;
        flag_mask = `IAO_MASK_LOGIC;
      end
      `IAO_OP_BITWISE_AND: begin
        op_result = p_ext & t_ext;
        flag_mask = `IAO_MASK_LOGIC;
      end
      `IAO_OP_BITWISE_XOR: begin
        op_result = p_ext ^ t_ext;
        flag_mask = `IAO_MASK_LOGIC;
      end
      `IAO_OP_LOGICAL_SHIFT, `IAO_OP_ARITH_SHIFT, `IAO_OP_FUNNEL_SHIFT: begin
        // Mixed precision has no defined shift width, so it is refused outright.
        op_refused = mixed_precision;
        flags[`IAO_F_INVALID] = mixed_precision;
        if (opcode == `IAO_OP_LOGICAL_SHIFT) begin
          op_result = logical_res;
        end else if (opcode == `IAO_OP_ARITH_SHIFT) begin
          op_result = arith_res;
        end else begin
          op_result = funnel_res;
        end
        flag_mask = `IAO_MASK_SHIFT;
      end
      `IAO_OP_MOVE: begin
        op_result  = p_operand;
        int_result = 1'b0;
        flag_mask  = `IAO_MASK_NONE;
      end
      `IAO_OP_MODE_LOAD: begin
        op_result  = result_reg;
        int_result = 1'b0;
        flag_mask  = `IAO_MASK_NONE;
      end
      default: begin
        op_known = 1'b0;
      end
    endcase
    // Only move and mode load ignore the class bit; the rest need it set.
    if (!int_class && (opcode != `IAO_OP_MOVE) && (opcode != `IAO_OP_MODE_LOAD)) begin
      op_known = 1'b0;
    end
    if (int_result && !out_double) begin
      op_result = {32'h00000000, op_result[31:0]};
    end
    if (int_result || opcode == `IAO_OP_INT_TO_FLOAT || opcode == `IAO_OP_INT_SCALED) begin
      flags[`IAO_F_ZERO] = out_double ? (op_result == 64'h0000000000000000)
                                      : (op_result[31:0] == 32'h00000000);
      flags[`IAO_F_SIGN] = out_double ? op_result[63] : op_result[31];
    end
    if (!op_known) begin
      op_refused = 1'b1;
      flag_mask  = `IAO_MASK_NONE;
    end
    if (op_refused && op_known) begin
      flag_mask = 13'h0000 | (13'h0001 << `IAO_F_INVALID);
    end
  end

  // ============================================================
  // Result, status and mode registers
  always @(posedge ref_clk) begin
    if (reset) begin
      result_reg       <= `IAO_RESULT_RESET;
      result_valid_reg <= 1'b0;
      op_refused_reg   <= 1'b0;
      status_reg       <= `IAO_STATUS_RESET;
      mode_reg         <= `IAO_MODE_RESET;
    end else begin
      result_valid_reg <= op_valid & ~op_refused & (opcode != `IAO_OP_MODE_LOAD);
      op_refused_reg   <= op_valid & op_refused;
      if (op_valid) begin
        if (!op_refused) begin
          result_reg <= op_result;
        end
        // Unrelated flags keep their old value rather than being cleared.
        status_reg <= (status_reg & ~flag_mask) | (flags & flag_mask);
        if (!op_refused && opcode == `IAO_OP_MODE_LOAD) begin
          mode_reg <= mode_source_port;
        end
      end
    end
  end

endmodule // iao_alu

// ### bench/iao_host.sv
// Host model that issues operation requests to the ALU.
`timescale 1ns/1ps
// ============================================================
// Host request driver
module iao_host (
  input  wire        ref_clk,
  output reg         op_valid,
  output reg  [4:0]  opcode,
  output reg         int_class,
  output reg         in_double,
  output reg         out_double,
  output reg         hex_format,
  output reg  [63:0] p_operand,
  output reg  [63:0] t_operand,
  output reg  [63:0] q_operand,
  output reg  [31:0] mode_source_port
);
  initial begin
    {op_valid, opcode, int_class, in_double, out_double, hex_format} = 10'h000;
    {p_operand, t_operand, q_operand, mode_source_port} = 224'h0;
  end

  // No sign-change controls are ever sent; opcode, class and precision decide whether a request is refused.
  task issue(input [4:0] op, input cls, input ind, input outd,
             input [63:0] p, input [63:0] t, input [63:0] q);
    begin
      @(posedge ref_clk);
      #1;
      {op_valid, opcode, int_class, in_double, out_double} = {1'b1, op, cls, ind, outd};
      {p_operand, t_operand, q_operand} = {p, t, q};
      @(posedge ref_clk);
      #1;
      op_valid = 1'b0;
      // Idle operands are scrambled so a stale value is never mistaken for a held one.
      {p_operand, t_operand, q_operand} = ~{p, t, q};
    end
  endtask
endmodule // iao_host

// ### bench/iao_alu_checker.sv
// Port-level assertions for the integer ALU operations.
`timescale 1ns/1ps
`include "iao_regs.vh"
// ============================================================
// Checker
module iao_alu_checker #(
  parameter WIDTH = 64
) (
  input wire                       ref_clk,
  input wire                       reset,
  input wire                       op_valid,
  input wire [4:0]                 opcode,
  input wire                       int_class,
  input wire                       in_double,
  input wire                       out_double,
  input wire                       hex_format,
  input wire [WIDTH-1:0]           p_operand,
  input wire [WIDTH-1:0]           t_operand,
  input wire [WIDTH-1:0]           q_operand,
  input wire [31:0]                mode_source_port,
  input wire [WIDTH-1:0]           result_reg,
  input wire                       result_valid_reg,
  input wire                       op_refused_reg,
  input wire [`IAO_FLAG_COUNT-1:0] status_reg,
  input wire [31:0]                mode_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire dbl = in_double && out_double;
  wire req = op_valid && int_class;

  AST_MODE_LOAD: assert property (op_valid && opcode == 5'h1f |=>
    mode_reg == $past(mode_source_port) && !result_valid_reg) else $error("mode load");
  AST_MOVE: assert property (op_valid && opcode == 5'h18 && dbl |=>
    result_reg == $past(p_operand) && $stable(status_reg)) else $error("move");
  AST_COMPARE: assert property (req && opcode == 5'h03 |=>
    $onehot(status_reg[11:9])) else $error("compare flags");
  AST_XOR_INVERT: assert property (req && opcode == 5'h12 && dbl && &t_operand |=>
    result_reg == ~$past(p_operand)) else $error("xor invert");
  AST_MIXED_SHIFT: assert property (req && opcode >= 5'h13 && opcode <= 5'h15
    && in_double != out_double |=> op_refused_reg && status_reg[1] && $stable(result_reg))
    else $error("mixed shift");
  AST_MAXIMUM: assert property (req && opcode == 5'h04 && dbl |=> result_reg ==
    (($signed($past(p_operand)) >= $signed($past(t_operand))) ? $past(p_operand)
    : $past(t_operand))) else $error("maximum");
  AST_LOGIC_MASK: assert property (req && opcode >= 5'h10 && opcode <= 5'h12 |=>
    (status_reg & 13'h1ef7) == ($past(status_reg) & 13'h1ef7)) else $error("logic flags");
  AST_ANSWER: assert property (req && opcode == 5'h10 |=> result_valid_reg ##1
    (!result_valid_reg || $past(op_valid))) else $error("valid pulse");
  AST_UNKNOWN_OP: assert property (op_valid && opcode == 5'h08 |=> op_refused_reg
    && $stable(status_reg) && $stable(result_reg)) else $error("unknown opcode");
endmodule // iao_alu_checker

bind iao_alu iao_alu_checker #(.WIDTH(WIDTH)) checker_i (.ref_clk(ref_clk), .reset(reset),
  .op_valid(op_valid), .opcode(opcode), .int_class(int_class), .in_double(in_double),
  .out_double(out_double), .hex_format(hex_format), .p_operand(p_operand),
  .t_operand(t_operand), .q_operand(q_operand), .mode_source_port(mode_source_port),
  .result_reg(result_reg), .result_valid_reg(result_valid_reg),
  .op_refused_reg(op_refused_reg), .status_reg(status_reg), .mode_reg(mode_reg));

// ### bench/integer_alu_operations_bench.sv
// Self-checking bench for the integer ALU operations.
`timescale 1ns/1ps
// ============================================================
// Bench top
module integer_alu_operations_bench;
  reg         ref_clk;
  reg         reset;
  wire        op_valid, int_class, in_double, out_double, hex_format;
  wire [4:0]  opcode;
  wire [63:0] p_operand, t_operand, q_operand, result_reg;
  wire [31:0] mode_source_port, mode_reg;
  wire        result_valid_reg, op_refused_reg;
  wire [12:0] status_reg;
  integer     n_fail, tests_run;
  reg  [63:0] keep;

  iao_host host (.ref_clk(ref_clk), .op_valid(op_valid), .opcode(opcode),
    .int_class(int_class), .in_double(in_double), .out_double(out_double),
    .hex_format(hex_format), .p_operand(p_operand), .t_operand(t_operand),
    .q_operand(q_operand), .mode_source_port(mode_source_port));
  iao_alu uut (.ref_clk(ref_clk), .reset(reset), .op_valid(op_valid), .opcode(opcode),
    .int_class(int_class), .in_double(in_double), .out_double(out_double),
    .hex_format(hex_format), .p_operand(p_operand), .t_operand(t_operand),
    .q_operand(q_operand), .mode_source_port(mode_source_port), .result_reg(result_reg),
    .result_valid_reg(result_valid_reg), .op_refused_reg(op_refused_reg),
    .status_reg(status_reg), .mode_reg(mode_reg));

  always #5 ref_clk = ~ref_clk;

  task chk(input [63:0] seen, input [63:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask

  // Same-precision request that must be accepted.
  task op(input [4:0] o, input d, input [63:0] p, input [63:0] t, input [63:0] q);
    begin
      host.issue(o, 1'b1, d, d, p, t, q);
      chk(result_valid_reg, 1'b1);
    end
  endtask

  task t_compare;
    begin
      op(5'h03, 1'b1, 64'h5, 64'h3, 64'h0);
      chk(status_reg[11:9], 3'b001);
      chk(status_reg[0], 1'b1);
      op(5'h03, 1'b1, 64'h3, 64'h5, 64'h0);
      chk(status_reg[11:9], 3'b100);
      chk(status_reg[0], 1'b0);
      op(5'h03, 1'b1, 64'h7, 64'h7, 64'h0);
      chk(status_reg[11:9], 3'b010);
      op(5'h01, 1'b1, {64{1'b1}}, 64'h1, 64'h0);
      chk(result_reg, 64'h0);
      chk(status_reg[0], 1'b1);
      chk(status_reg[8], 1'b1);
    end
  endtask

  task t_maxmin;
    begin
      op(5'h04, 1'b1, 64'hfffffffffffffffe, 64'h1, 64'h0);
      chk(result_reg, 64'h1);
      chk(status_reg[6], 1'b1);
      op(5'h05, 1'b1, 64'hfffffffffffffffe, 64'h1, 64'h0);
      chk(result_reg, 64'hfffffffffffffffe);
      chk(status_reg[6], 1'b0);
    end
  endtask

  task t_logic;
    begin
      host.issue(5'h10, 1'b1, 1'b0, 1'b1, 64'h80000000, 64'h1, 64'h0);
      chk(result_reg, 64'hffffffff80000001);
      host.issue(5'h11, 1'b1, 1'b0, 1'b1, 64'h80000000, 64'hf0000000, 64'h0);
      chk(result_reg, 64'hffffffff80000000);
      op(5'h12, 1'b1, 64'h0123456789abcdef, {64{1'b1}}, 64'h0);
      chk(result_reg, 64'hfedcba9876543210);
      chk(status_reg[3], 1'b1);
    end
  endtask

  task t_shift;
    begin
      op(5'h13, 1'b1, 64'h8000000000000001, 64'h0, 64'h4);
      chk(result_reg, 64'h0800000000000000);
      op(5'h13, 1'b1, 64'h8000000000000001, 64'h0, 64'hfffffffffffffffc);
      chk(result_reg, 64'h10);
      op(5'h13, 1'b1, 64'h8000000000000001, 64'h0, 64'hffffffffffffffc0);
      chk(result_reg, 64'h0);
      op(5'h14, 1'b1, 64'h8000000000000000, 64'h0, 64'h3f);
      chk(result_reg, {64{1'b1}});
      op(5'h14, 1'b0, 64'h80000000, 64'h0, 64'h1f);
      chk(result_reg, 64'hffffffff);
      op(5'h15, 1'b1, 64'h1122334455667788, 64'h99aabbccddeeff00, 64'h8);
      chk(result_reg, 64'h8899aabbccddeeff);
      op(5'h15, 1'b1, 64'h1122334455667788, 64'h99aabbccddeeff00, 64'hfffffffffffffff8);
      chk(result_reg, 64'haabbccddeeff0011);
      keep = result_reg;
      host.issue(5'h13, 1'b1, 1'b1, 1'b0, 64'h1, 64'h0, 64'h1);
      chk(op_refused_reg, 1'b1);
      chk(status_reg[1], 1'b1);
      chk(result_reg, keep);
    end
  endtask

  task t_convert;
    begin
      op(5'h06, 1'b1, 64'h0, 64'h1, 64'h0);
      chk(result_reg, 64'h3ff0000000000000);
      op(5'h06, 1'b0, 64'h0, 64'h1, 64'h0);
      chk(result_reg, 64'h3f800000);
      op(5'h07, 1'b1, 64'h0, 64'h1, 64'h4000000000000000);
      chk(result_reg, 64'h4000000000000000);
      host.hex_format = 1'b1;
      op(5'h07, 1'b1, 64'h0, 64'h1, 64'h4000000000000000);
      chk(result_reg, 64'h4030000000000000);
      host.hex_format = 1'b0;
    end
  endtask

  task t_misc;
    begin
      keep = {51'h0, status_reg};
      host.issue(5'h18, 1'b0, 1'b1, 1'b1, 64'hdeadbeef01234567, 64'h0, 64'h0);
      chk(result_reg, 64'hdeadbeef01234567);
      chk(status_reg, keep);
      host.mode_source_port = 32'h12345678;
      host.issue(5'h1f, 1'b0, 1'b1, 1'b1, 64'h0, 64'h0, 64'h0);
      chk(mode_reg, 32'h12345678);
      chk(result_valid_reg, 1'b0);
      host.issue(5'h08, 1'b1, 1'b1, 1'b1, 64'h0, 64'h0, 64'h0);
      chk(op_refused_reg, 1'b1);
      host.issue(5'h10, 1'b0, 1'b1, 1'b1, 64'h0, 64'h0, 64'h0);
      chk(op_refused_reg, 1'b1);
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    n_fail = 0;
    tests_run = 0;
    keep = 64'h0;
    repeat (6) @(posedge ref_clk);
    #1 reset = 1'b0;
    t_compare;
    t_maxmin;
    t_logic;
    t_shift;
    t_convert;
    t_misc;
    print_verdict;
  end

  // The scenarios need well under a thousand cycles; this cuts a hang short.
  initial begin
    #20000;
    n_fail = n_fail + 1;
    print_verdict;
  end
endmodule // integer_alu_operations_bench
